// File: bmst_pkg.sv
// package: types and constants for the system-bus master state machine
package bmst_pkg;
   // transfer type encodings on the bus transfer lanes
   localparam logic [1:0] TRAN_ADDR_ONLY = 2'h0;
   localparam logic [1:0] TRAN_NONSEQ = 2'h2;
   localparam logic [1:0] TRAN_SEQ = 2'h3;
   // transfer size and protection defaults
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] PROT_SUPER_DATA = 2'h3;
   // fifo defaults
   localparam int FIFO_DEPTH = 16;
   localparam int WORD_W = 32;
   // six states of the master engine
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_HOLD,
      ST_HANDOVER,
      ST_ACTIVE,
      ST_LAST,
      ST_ERROR
   } mstate_t;
   // latched slave response
   typedef struct packed {
      logic wait_r;
      logic err_r;
      logic last_r;
   } resp_t;
   // transfer request from the dma side
   typedef struct packed {
      logic [31:0] addr;
      logic write;
      logic [31:0] wdata;
   } xreq_t;
endpackage

// File: word_fifo.sv
// file: parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rp_r];
   // pointer and count upkeep
   always_ff @(posedge clk) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
         if (pop) rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   // storage write
   always_ff @(posedge clk) begin
      if (push) mem_r[wp_r] <= in_data;
   end
endmodule // word_fifo

// File: asb_master_fsm.sv
// file: falling-edge system-bus master state machine with read-data fifo
// Operation
// - one control machine, six states, switching on the falling clock edge
// - two granted states handle turnaround; retract is not built
// - internal request high while a transfer is needed, low otherwise
// - outside active only granted/request steer; active follows the response
// - after requesting, drop request and hold lock while grant still needed
// - exit from active uses latched wait, error and last
// - no granted-without-request idle state
// - with grant low in reset, machine leaves reset in idle
// - idle: address-only type, clock enabled, address and data floated
// - hold: address-only type, clock gated, address and data floated
// - handover: sequential type, clock off, address enable from granted
// - active: master type, clock enable from wait, data only on writes
// - transfer-type drivers on only when grant and clock both high
// - one address enable gates address group; separate data enable
// - address and control launched from the rising clock edge
// - sequential write data may launch from the falling edge
// - bus reset acts asynchronously on assertion, except in the read fifo, which clears on the rising edge
// - arbitration request changes in high phase; grant in low phase
// - each cycle: phase one clock low, phase two clock high
`timescale 1ns/1ps
module asb_master_fsm #(
   parameter int WIDTH = bmst_pkg::WORD_W,
   parameter int DEPTH = bmst_pkg::FIFO_DEPTH
) (
   input wire logic BCLK,
   input wire logic BNRES_N,
   input wire logic AGNT,
   output logic AREQ,
   input wire logic BWAIT,
   input wire logic BERROR,
   input wire logic BLAST,
   output logic [31:0] BA_O,
   output logic BA_OE_N,
   output logic BWRITE_O,
   output logic [1:0] BSIZE_O,
   output logic [1:0] BPROT_O,
   output logic BLOK_O,
   output logic [1:0] BTRAN_O,
   output logic BTRAN_OE_N,
   input wire logic [31:0] BD_I,
   output logic [31:0] BD_O,
   output logic BD_OE_N,
   input wire logic XFER_VALID,
   output logic XFER_READY,
   input wire logic [31:0] XFER_ADDR,
   input wire logic XFER_WRITE,
   input wire logic [31:0] XFER_WDATA,
   output logic XFER_ERROR,
   output logic RD_VALID,
   input wire logic RD_READY,
   output logic [WIDTH-1:0] RD_DATA,
   output logic MCLK_EN
);
   bmst_pkg::mstate_t state_r, state_nxt;
   bmst_pkg::resp_t resp_r;
   bmst_pkg::xreq_t cur_r;
   logic gnt_r;
   logic request;
   logic need_r;
   logic areq_r;
   logic lok_r;
   logic [31:0] addr_r;
   logic write_r;
   logic seq_r;
   logic [31:0] wdata_r;
   logic err_r;
   logic fifo_in_ready;
   logic rd_capture_r;
   logic [WIDTH-1:0] rd_word_r;
   wire rst = !BNRES_N;

   // accept a new dma transfer only when idle and the fifo has space
   assign XFER_READY = (state_r == bmst_pkg::ST_IDLE) && !need_r && fifo_in_ready;
   assign request = XFER_VALID && XFER_READY;

   // pending-transfer latch, cleared when the transfer completes
   always_ff @(negedge BCLK or negedge BNRES_N) begin
      if (!BNRES_N) begin
         need_r <= 1'b0;
         cur_r <= '0;
      end else if (request) begin
         need_r <= 1'b1;
         cur_r <= '{addr: XFER_ADDR, write: XFER_WRITE, wdata: XFER_WDATA};
      end else if (state_r == bmst_pkg::ST_LAST || state_r == bmst_pkg::ST_ERROR) begin
         need_r <= 1'b0;
      end
   end

   // response latches, captured on the rising edge at end of phase 1
   // the state register moves half a cycle later, so it never reads a
   // response that is still settling in the low phase
   always_ff @(posedge BCLK or negedge BNRES_N) begin
      if (!BNRES_N) resp_r <= '0;
      else resp_r <= '{wait_r: BWAIT, err_r: BERROR, last_r: BLAST};
   end

   // grant sampled when stable; arbiter changes it in the low phase
   always_ff @(posedge BCLK or negedge BNRES_N) begin
      if (!BNRES_N) gnt_r <= 1'b0;
      else gnt_r <= AGNT;
   end

   // next-state logic; no granted-idle and no retract path
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         bmst_pkg::ST_IDLE: begin
            if (request || need_r) state_nxt = gnt_r ? bmst_pkg::ST_HANDOVER : bmst_pkg::ST_HOLD;
         end
         bmst_pkg::ST_HOLD: begin
            if (gnt_r) state_nxt = bmst_pkg::ST_HANDOVER;
         end
         bmst_pkg::ST_HANDOVER: begin
            state_nxt = gnt_r ? bmst_pkg::ST_ACTIVE : bmst_pkg::ST_HOLD;
         end
         bmst_pkg::ST_ACTIVE: begin
            if (resp_r.err_r) state_nxt = bmst_pkg::ST_ERROR;
            else if (resp_r.wait_r) state_nxt = bmst_pkg::ST_ACTIVE;
            else if (resp_r.last_r) state_nxt = bmst_pkg::ST_LAST;
            else state_nxt = bmst_pkg::ST_LAST; // done: single word
         end
         bmst_pkg::ST_LAST: state_nxt = bmst_pkg::ST_IDLE;
         bmst_pkg::ST_ERROR: state_nxt = bmst_pkg::ST_IDLE;
      endcase
   end

   // state register on the falling edge
   always_ff @(negedge BCLK or negedge BNRES_N) begin
      if (!BNRES_N) state_r <= bmst_pkg::ST_IDLE;
      else state_r <= state_nxt;
   end

   // bus not yet owned: request still wanted, lock not yet due
   function automatic logic unowned(input bmst_pkg::mstate_t s);
      return (s == bmst_pkg::ST_HOLD) || (s == bmst_pkg::ST_IDLE);
   endfunction

   // request and lock launched in the high phase from the rising edge
   // request drops once the handover starts; lock keeps the grant after that
   always_ff @(posedge BCLK or negedge BNRES_N) begin
      if (!BNRES_N) begin
         areq_r <= 1'b0;
         lok_r <= 1'b0;
      end else begin
         areq_r <= need_r && unowned(state_r);
         lok_r <= need_r && !unowned(state_r);
      end
   end
   assign AREQ = areq_r;
   assign BLOK_O = lok_r;

   // address and control launched from the rising edge
   always_ff @(posedge BCLK or negedge BNRES_N) begin
      if (!BNRES_N) begin
         addr_r <= '0;
         write_r <= 1'b0;
         seq_r <= 1'b0;
      end else begin
         addr_r <= cur_r.addr;
         write_r <= cur_r.write;
         seq_r <= (state_r == bmst_pkg::ST_ACTIVE);
      end
   end

   // write data launched on the falling edge for early drive
   always_ff @(negedge BCLK or negedge BNRES_N) begin
      if (!BNRES_N) wdata_r <= '0;
      else wdata_r <= cur_r.wdata;
   end

   // per-state actions
   wire in_idle = (state_r == bmst_pkg::ST_IDLE);
   wire in_hold = (state_r == bmst_pkg::ST_HOLD);
   wire in_hand = (state_r == bmst_pkg::ST_HANDOVER);
   wire in_act = (state_r == bmst_pkg::ST_ACTIVE);
   wire addr_en = (in_hand || in_act) && gnt_r && BNRES_N;
   wire data_en = in_act && write_r && BNRES_N;
   wire [1:0] tran_int = in_hand ? bmst_pkg::TRAN_SEQ :
                        in_act ? (seq_r ? bmst_pkg::TRAN_SEQ : bmst_pkg::TRAN_NONSEQ) :
                        bmst_pkg::TRAN_ADDR_ONLY;
   assign MCLK_EN = in_idle ? 1'b1 : (in_act ? !resp_r.wait_r : 1'b0);
   assign BTRAN_O = tran_int;
   assign BTRAN_OE_N = !(AGNT && BCLK && BNRES_N);
   assign BA_OE_N = !addr_en;
   assign BA_O = addr_r;
   assign BWRITE_O = write_r;
   assign BSIZE_O = bmst_pkg::SIZE_WORD;
   assign BPROT_O = bmst_pkg::PROT_SUPER_DATA;
   assign BD_OE_N = !data_en;
   assign BD_O = wdata_r;

   // read data captured at completion into the fifo
   // the word is taken on the falling edge that ends the transfer: the
   // address group is withdrawn on that same edge, so the lanes are no
   // longer valid by the next rising edge when the fifo pushes
   always_ff @(negedge BCLK or negedge BNRES_N) begin
      if (!BNRES_N) begin
         rd_capture_r <= 1'b0;
         rd_word_r <= '0;
         err_r <= 1'b0;
      end else begin
         rd_capture_r <= in_act && !resp_r.wait_r && !resp_r.err_r && !write_r;
         rd_word_r <= BD_I[WIDTH-1:0]; // sampled at the falling edge
         err_r <= (state_nxt == bmst_pkg::ST_ERROR) || (err_r && !request);
      end
   end
   assign XFER_ERROR = err_r;

   word_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_rd_fifo (
      .clk(BCLK),
      .rst(rst),
      .in_valid(rd_capture_r),
      .in_ready(fifo_in_ready),
      .in_data(rd_word_r),
      .out_valid(RD_VALID),
      .out_ready(RD_READY),
      .out_data(RD_DATA)
   );
endmodule // asb_master_fsm

// File: bus_partner.sv
// partner: arbiter, decoder and slave facing the bus master
`timescale 1ns/1ps
module bus_partner (
   input wire logic BCLK,
   input wire logic BNRES_N,
   input wire logic AREQ,
   input wire logic BLOK_O,
   input wire logic BA_OE_N,
   input wire logic [3:0] wait_n,
   input wire logic err,
   input wire logic [31:0] rdata,
   output logic AGNT,
   output logic BWAIT,
   output logic BERROR,
   output logic BLAST,
   output logic [31:0] BD_I
);
   logic [3:0] cnt_r;
   logic sel;
   // responses from the selected slave
   assign sel = !BA_OE_N;
   assign BWAIT = sel && cnt_r < wait_n;
   assign BERROR = sel && !BWAIT && err;
   assign BLAST = sel && !BWAIT && !err;
   assign BD_I = (sel && !BWAIT) ? rdata : ~rdata; // released lanes show inverse
   // grant and responses move in the low phase
   always @(negedge BCLK or negedge BNRES_N) begin
      if (!BNRES_N) begin
         AGNT <= 1'b0;
         cnt_r <= 4'h0;
      end else begin
         AGNT <= AREQ || (AGNT && BLOK_O); // locked owner keeps grant
         cnt_r <= sel ? cnt_r + {3'h0, cnt_r < wait_n} : 4'h0;
      end
   end
endmodule // bus_partner

// File: asb_master_fsm_properties.sv
// checker: port assertions of the bus master
`timescale 1ns/1ps
module asb_master_fsm_chk (
   input wire logic BCLK,
   input wire logic BNRES_N,
   input wire logic AGNT,
   input wire logic AREQ,
   input wire logic BERROR,
   input wire logic BA_OE_N,
   input wire logic BWRITE_O,
   input wire logic BLOK_O,
   input wire logic BTRAN_OE_N,
   input wire logic BD_OE_N,
   input wire logic XFER_VALID,
   input wire logic XFER_READY,
   input wire logic XFER_ERROR,
   input wire logic MCLK_EN
);
   default clocking cb @(posedge BCLK); endclocking
   default disable iff (!BNRES_N);
   // request accepted by the engine
   sequence s_take;
      XFER_VALID && XFER_READY;
   endsequence
   // the engine takes a request on the falling edge, so look there
   AST_REQ_AFTER_TAKE: assert property (@(negedge BCLK) s_take |-> ##[1:4] AREQ)
      else $error("no request after take");
   AST_BUSY_REFUSES: assert property (AREQ |-> !XFER_READY)
      else $error("ready while requesting");
   AST_HOLD_CLK_OFF: assert property (AREQ |-> !MCLK_EN)
      else $error("clock on in hold");
   AST_IDLE_FLOAT: assert property (XFER_READY |-> BA_OE_N && BD_OE_N && MCLK_EN)
      else $error("idle not floated");
   AST_ADDR_FROM_GRANT: assert property (!BA_OE_N |-> $past(AGNT))
      else $error("address without grant");
   AST_DATA_WRITE_ONLY: assert property (!BD_OE_N |-> BWRITE_O && !BA_OE_N)
      else $error("data lanes on read");
   AST_LOCK_ON_DROP: assert property ($fell(AREQ) |-> BLOK_O)
      else $error("lock low at drop");
   AST_ERR_CAUSE: assert property ($rose(XFER_ERROR) |-> $past(BERROR) || $past(BERROR, 2))
      else $error("error flag without cause");
   AST_TRAN_OE: assert property (@(negedge BCLK) !BTRAN_OE_N == AGNT)
      else $error("type enable wrong");
   AST_RESET_FLOAT: assert property (disable iff (1'b0) !BNRES_N |-> !AREQ && BA_OE_N && BD_OE_N)
      else $error("outputs live in reset");
endmodule // asb_master_fsm_chk
bind asb_master_fsm asb_master_fsm_chk chk (.BCLK, .BNRES_N, .AGNT, .AREQ, .BERROR,
   .BA_OE_N, .BWRITE_O, .BLOK_O, .BTRAN_OE_N, .BD_OE_N, .XFER_VALID, .XFER_READY,
   .XFER_ERROR, .MCLK_EN);

// File: tb_asb_master_fsm.sv
// testbench: scenarios for the bus master
`timescale 1ns/1ps
module tb_asb_master_fsm;
   logic BCLK = 0, BNRES_N = 0, AGNT, AREQ, BWAIT, BERROR, BLAST, BA_OE_N, BWRITE_O;
   logic BLOK_O, BTRAN_OE_N, BD_OE_N, XFER_VALID = 0, XFER_READY, XFER_WRITE = 0;
   logic XFER_ERROR, RD_VALID, RD_READY = 0, MCLK_EN, err = 0, got_w;
   logic [1:0] BSIZE_O, BPROT_O, BTRAN_O, got_t;
   logic [3:0] wait_n = 4'h0;
   logic [31:0] BA_O, BD_I, BD_O, RD_DATA, got_a, got_d, XFER_ADDR = 32'h0;
   logic [31:0] XFER_WDATA = 32'h0, rdata = 32'h0;
   int fails = 0, n_compared = 0;
   always #10 BCLK = ~BCLK;
   asb_master_fsm dut (.BCLK, .BNRES_N, .AGNT, .AREQ, .BWAIT, .BERROR, .BLAST, .BA_O,
      .BA_OE_N, .BWRITE_O, .BSIZE_O, .BPROT_O, .BLOK_O, .BTRAN_O, .BTRAN_OE_N, .BD_I,
      .BD_O, .BD_OE_N, .XFER_VALID, .XFER_READY, .XFER_ADDR, .XFER_WRITE, .XFER_WDATA,
      .XFER_ERROR, .RD_VALID, .RD_READY, .RD_DATA, .MCLK_EN);
   bus_partner far (.BCLK, .BNRES_N, .AREQ, .BLOK_O, .BA_OE_N, .wait_n, .err, .rdata,
      .AGNT, .BWAIT, .BERROR, .BLAST, .BD_I);
   task automatic report_and_stop;
      if (fails == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one transfer, capturing address and write data
   task automatic go(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int i;
      @(posedge BCLK);
      XFER_WRITE <= wr;
      XFER_ADDR <= a;
      XFER_WDATA <= d;
      XFER_VALID <= 1'b1;
      @(posedge BCLK);
      XFER_VALID <= 1'b0;
      for (i = 0; i < 40 && BA_OE_N !== 1'b0; i++) begin
         @(posedge BCLK);
         #5;
      end
      if (i >= 40) begin
         fails++;
         report_and_stop();
      end
      got_a = BA_O;
      got_t = BTRAN_O;
      got_w = BWRITE_O;
      for (i = i; i < 80 && BA_OE_N === 1'b0; i++) begin
         if (BD_OE_N === 1'b0) got_d = BD_O;
         @(posedge BCLK);
         #5;
      end
      if (i >= 80) begin
         fails++;
         report_and_stop();
      end
      repeat (3) @(posedge BCLK);
      #5;
   endtask
   task automatic pop;
      @(posedge BCLK) RD_READY <= 1'b1;
      @(posedge BCLK) RD_READY <= 1'b0;
      #5;
   endtask
   task automatic t_read(input logic [3:0] w, input logic [31:0] v);
      wait_n <= w;
      rdata <= v;
      go(1'b0, 32'h40, 32'h0);
      chk("BA_O", 32'h40, got_a);
      chk("BTRAN_O", bmst_pkg::TRAN_SEQ, got_t);
      chk("BWRITE_O", 32'h0, got_w);
      chk("RD_VALID", 32'h1, RD_VALID);
      chk("RD_DATA", v, RD_DATA);
      pop();
   endtask
   task automatic t_write;
      go(1'b1, 32'h80, 32'hA5A50F0F);
      chk("BD_O", 32'hA5A50F0F, got_d);
      chk("BWRITE_O", 32'h1, got_w);
      chk("BSIZE_O", bmst_pkg::SIZE_WORD, BSIZE_O);
      chk("BPROT_O", bmst_pkg::PROT_SUPER_DATA, BPROT_O);
      chk("RD_VALID", 32'h0, RD_VALID);
   endtask
   task automatic t_fill;
      int k;
      for (k = 0; k < 16; k++) begin
         rdata <= 32'h100 + k;
         go(1'b0, 32'h200, 32'h0);
      end
      chk("XFER_READY", 32'h0, XFER_READY);
      for (k = 0; k < 16; k++) begin
         chk("RD_DATA", 32'h100 + k, RD_DATA);
         pop();
      end
      chk("RD_VALID", 32'h0, RD_VALID);
   endtask
   task automatic t_error;
      err <= 1'b1;
      go(1'b0, 32'h300, 32'h0);
      chk("XFER_ERROR", 32'h1, XFER_ERROR);
      err <= 1'b0;
      go(1'b1, 32'h304, 32'h1);
      chk("XFER_ERROR", 32'h0, XFER_ERROR);
   endtask
   initial begin
      repeat (9) @(posedge BCLK);
      #5;
      chk("AREQ", 32'h0, AREQ);
      chk("XFER_READY", 32'h1, XFER_READY);
      @(posedge BCLK) BNRES_N <= 1'b1;
      t_read(4'h0, 32'h12345678);
      t_read(4'h3, 32'h9ABCDEF0);
      t_write();
      t_fill();
      t_error();
      report_and_stop();
   end
endmodule // tb_asb_master_fsm
